// ---- core/lvs_pkg.sv ----
// Package of offsets, field positions and reset values for the sequencer register bank
package lvs_pkg;
  localparam logic [15:0] IO_SEQ_INDEX  = 16'h03c4;
  localparam logic [15:0] IO_SEQ_DATA   = 16'h03c5;
  localparam logic [15:0] IO_GFX_INDEX  = 16'h03ce;
  localparam logic [15:0] IO_GFX_DATA   = 16'h03cf;
  localparam logic [2:0]  IDX_LEGACY_RESET = 3'h0;
  localparam logic [2:0]  IDX_CLOCKING     = 3'h1;
  localparam logic [2:0]  IDX_PLANE_MASK   = 3'h2;
  localparam logic [2:0]  IDX_FONT_MAP     = 3'h3;
  localparam logic [2:0]  IDX_MEM_MODE     = 3'h4;
  localparam logic [2:0]  IDX_CHAR_HOLD    = 3'h7;
  localparam logic [7:0]  RST_REG          = 8'h00;
  localparam logic [2:0]  RST_SEQ_INDEX    = 3'h0;
  localparam logic [4:0]  RST_GFX_INDEX    = 5'h00;
  localparam logic [7:0]  CLK_MODE_MASK    = 8'h3d;
  localparam logic [7:0]  PLANE_MASK_MASK  = 8'h0f;
  localparam logic [7:0]  FONT_MASK        = 8'h3f;
  localparam logic [7:0]  MEM_MODE_MASK    = 8'h0e;
  localparam int          CLK_DOT8_BIT     = 0;
  localparam int          CLK_HALF_LOAD_BIT = 2;
  localparam int          CLK_DOT_DIV_BIT  = 3;
  localparam int          CLK_QUAD_LOAD_BIT = 4;
  localparam int          CLK_SCREEN_OFF_BIT = 5;
  localparam int          MEM_EXT_BIT      = 1;
  localparam int          MEM_ODD_EVEN_BIT = 2;
  localparam int          MEM_CHAIN4_BIT   = 3;
  localparam logic [3:0]  DOTS_NARROW      = 4'h8;
  localparam logic [3:0]  DOTS_WIDE        = 4'h9;
  localparam logic [2:0]  LOAD_EVERY_1     = 3'h1;
  localparam logic [2:0]  LOAD_EVERY_2     = 3'h2;
  localparam logic [2:0]  LOAD_EVERY_4     = 3'h4;
endpackage

// ---- core/lvs_plane_route.sv ----
// Plane select and address window for host frame buffer accesses
`timescale 1ns/1ps
module lvs_plane_route (
  input  wire logic [7:0]  mem_mode_i,
  input  wire logic [3:0]  plane_mask_i,
  input  wire logic [17:0] cpu_addr_i,
  output logic      [3:0]  plane_sel_o,
  output logic             addr_ok_o
);
  logic chain4;
  logic odd_even_off;

  assign chain4       = mem_mode_i[lvs_pkg::MEM_CHAIN4_BIT];
  assign odd_even_off = mem_mode_i[lvs_pkg::MEM_ODD_EVEN_BIT];

  // Mask gates every mode, so no plane escapes it, see R08
  always_comb begin
    if (chain4) begin
      plane_sel_o = (4'h1 << cpu_addr_i[1:0]) & plane_mask_i; // see R13
    end else if (!odd_even_off) begin
      plane_sel_o = (cpu_addr_i[0] ? 4'ha : 4'h5) & plane_mask_i; // see R14
    end else begin
      plane_sel_o = plane_mask_i; // see R14
    end
  end

  // Only the first 64 KB without extended memory
  assign addr_ok_o = mem_mode_i[lvs_pkg::MEM_EXT_BIT] || (cpu_addr_i[17:16] == 2'h0); // see R15
endmodule

// ---- core/lvs_seq_regs.sv ----
// Sequencer register bank behind the legacy index/data I/O ports
`timescale 1ns/1ps
// Contract
// R01: Screen off blanks video, stops fetch, keeps sync
// R02: Screen off ignored while legacy plane disabled
// R03: Host sets screen off, waits, then disables
// R04: Quad load reloads every fourth character clock
// R05: Dot divide halves the pixel clock
// R06: Half load every other clock unless quad
// R07: Character width nine or eight dot clocks
// R08: Plane mask gates CPU writes per plane
// R09: Differing font maps make attribute bit select
// R10: Font select only with extended memory enabled
// R11: Secondary map number bit5 over bits 3:2
// R12: Primary map number bit4 over bits 1:0
// R13: Chain four uses address bits as plane
// R14: Odd even pairs planes, else sequential masked
// R15: Extended memory opens 256KB, else 64KB
// R16: Character hold register never stalls counters
// R17: Graphics index at 3CEh, data at 3CFh
// R18: Graphics indexes 10 and 11 only I/O
// R19: Sequencer index at 3C4h, data at 3C5h
// R20: Reserved bits read zero, writes ignored
// R21: Writes take effect immediately, no buffering
module lvs_seq_regs (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        legacy_plane_disable_i,
  input  wire logic        text_mode_i,
  input  wire logic        attr_bit3_i,
  input  wire logic        cpu_wr_i,
  input  wire logic [17:0] cpu_addr_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rvalid_o,
  output logic             video_blank_o,
  output logic             fetch_enable_o,
  output logic      [2:0]  load_interval_o,
  output logic             pixel_div2_o,
  output logic      [3:0]  char_dots_o,
  output logic      [3:0]  plane_write_en_o,
  output logic             cpu_addr_ok_o,
  output logic             font_select_o,
  output logic             fg_intensity_o,
  output logic      [15:0] font_base_o,
  output logic      [4:0]  gfx_controller_index_o
);
  typedef struct packed {
    logic [2:0]  sequencer_index_port;
    logic [7:0]  clocking_mode;
    logic [7:0]  plane_write_mask;
    logic [7:0]  font_map_select;
    logic [7:0]  memory_addressing_mode;
    logic [7:0]  char_counter_hold;
    logic [4:0]  gfx_controller_index;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        blank;
    logic        fetch;
    logic [2:0]  load_int;
    logic        div2;
    logic [3:0]  dots;
    logic [3:0]  wr_en;
    logic        addr_ok;
    logic        font_sel;
    logic        intensity;
    logic [15:0] font_base;
  } lvs_state_t;

  lvs_state_t st;
  lvs_state_t next_st;
  logic [3:0] route_sel;
  logic       route_ok;
  logic [7:0] clk_mode_now;
  logic [7:0] mem_mode_now;
  logic [7:0] font_now;

  // Map number: high bit over two low bits; low bits step 16 KB, high bit adds 8 KB
  function automatic logic [15:0] font_offset(input logic hi, input logic [1:0] lo);
    font_offset = {lo, hi, 13'h0000}; // see R11
  endfunction

  function automatic logic [7:0] seq_read(input lvs_state_t s);
    unique case (s.sequencer_index_port)
      lvs_pkg::IDX_CLOCKING:   seq_read = s.clocking_mode;
      lvs_pkg::IDX_PLANE_MASK: seq_read = s.plane_write_mask;
      lvs_pkg::IDX_FONT_MAP:   seq_read = s.font_map_select;
      lvs_pkg::IDX_MEM_MODE:   seq_read = s.memory_addressing_mode;
      lvs_pkg::IDX_CHAR_HOLD:  seq_read = s.char_counter_hold;
      default:                 seq_read = lvs_pkg::RST_REG; // see R20
    endcase
  endfunction

  lvs_plane_route u_route (
    .mem_mode_i   (mem_mode_now),
    .plane_mask_i (next_st.plane_write_mask[3:0]),
    .cpu_addr_i   (cpu_addr_i),
    .plane_sel_o  (route_sel),
    .addr_ok_o    (route_ok)
  );

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    // Registers written on the index and data ports (see R19)
    if (io_wr_i && io_addr_i == lvs_pkg::IO_SEQ_INDEX) begin
      next_st.sequencer_index_port = io_wdata_i[2:0]; // see R20
    end
    if (io_wr_i && io_addr_i == lvs_pkg::IO_GFX_INDEX) begin
      next_st.gfx_controller_index = io_wdata_i[4:0]; // see R17
    end
    if (io_wr_i && io_addr_i == lvs_pkg::IO_SEQ_DATA) begin
      unique case (st.sequencer_index_port)
        lvs_pkg::IDX_CLOCKING:
          next_st.clocking_mode = io_wdata_i & lvs_pkg::CLK_MODE_MASK; // see R20
        lvs_pkg::IDX_PLANE_MASK:
          next_st.plane_write_mask = io_wdata_i & lvs_pkg::PLANE_MASK_MASK;
        lvs_pkg::IDX_FONT_MAP:
          next_st.font_map_select = io_wdata_i & lvs_pkg::FONT_MASK;
        lvs_pkg::IDX_MEM_MODE:
          next_st.memory_addressing_mode = io_wdata_i & lvs_pkg::MEM_MODE_MASK;
        // Stored only; the counter is never held, see R16
        lvs_pkg::IDX_CHAR_HOLD: next_st.char_counter_hold = io_wdata_i;
        default: ;
      endcase
    end
    // Reads answer one cycle after the strobe
    if (io_rd_i) begin
      next_st.rvalid = 1'b1;
      if (io_addr_i == lvs_pkg::IO_SEQ_INDEX) begin
        next_st.rdata = {5'h00, st.sequencer_index_port};
      end else if (io_addr_i == lvs_pkg::IO_SEQ_DATA) begin
        next_st.rdata = seq_read(st);
      end else if (io_addr_i == lvs_pkg::IO_GFX_INDEX) begin
        next_st.rdata = {3'h0, st.gfx_controller_index}; // see R17
      end else begin
        next_st.rdata = 8'h00;
        next_st.rvalid = 1'b0;
      end
    end
  end

  // Controls follow the newly written value straight away, see R21
  assign clk_mode_now = next_st.clocking_mode;
  assign mem_mode_now = next_st.memory_addressing_mode;
  assign font_now     = next_st.font_map_select;

  lvs_state_t ctl;
  logic       ext_mem;
  logic       fonts_differ;
  always_comb begin
    ctl = next_st;
    ext_mem = mem_mode_now[lvs_pkg::MEM_EXT_BIT];
    // Screen off has no effect once the plane is disabled
    ctl.blank = clk_mode_now[lvs_pkg::CLK_SCREEN_OFF_BIT] && !legacy_plane_disable_i; // see R01 R02
    ctl.fetch = !ctl.blank; // see R01
    if (clk_mode_now[lvs_pkg::CLK_QUAD_LOAD_BIT]) begin
      ctl.load_int = lvs_pkg::LOAD_EVERY_4; // see R04
    end else if (clk_mode_now[lvs_pkg::CLK_HALF_LOAD_BIT]) begin
      ctl.load_int = lvs_pkg::LOAD_EVERY_2; // see R06
    end else begin
      ctl.load_int = lvs_pkg::LOAD_EVERY_1;
    end
    ctl.div2 = clk_mode_now[lvs_pkg::CLK_DOT_DIV_BIT]; // see R05
    // Count in pixel clocks; divide doubles it downstream
    ctl.dots = clk_mode_now[lvs_pkg::CLK_DOT8_BIT] ? lvs_pkg::DOTS_NARROW
                                                   : lvs_pkg::DOTS_WIDE; // see R07
    ctl.wr_en = (cpu_wr_i && route_ok) ? route_sel : 4'h0; // see R08
    ctl.addr_ok = route_ok; // see R15
    // Without extended memory only maps 0 and 4 are reachable
    fonts_differ = ext_mem && (font_now[3:2] != font_now[1:0] || font_now[5] != font_now[4]);
    ctl.font_sel = text_mode_i && fonts_differ && attr_bit3_i; // see R09 R10
    ctl.intensity = text_mode_i && !fonts_differ && attr_bit3_i; // see R09
    if (!ext_mem) begin
      ctl.font_base = font_offset(fonts_differ ? font_now[5] : font_now[4], 2'h0); // see R10
    end else if (ctl.font_sel) begin
      ctl.font_base = font_offset(font_now[5], font_now[3:2]); // see R11
    end else begin
      ctl.font_base = font_offset(font_now[4], font_now[1:0]); // see R12
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.fetch <= 1'b1;
      st.load_int <= lvs_pkg::LOAD_EVERY_1;
      st.dots <= lvs_pkg::DOTS_WIDE;
      st.addr_ok <= 1'b1;
    end else begin
      st <= ctl;
    end
  end

  assign io_rdata_o             = st.rdata;
  assign io_rvalid_o            = st.rvalid;
  assign video_blank_o          = st.blank;
  assign fetch_enable_o         = st.fetch;
  assign load_interval_o        = st.load_int;
  assign pixel_div2_o           = st.div2;
  assign char_dots_o            = st.dots;
  assign plane_write_en_o       = st.wr_en;
  assign cpu_addr_ok_o          = st.addr_ok;
  assign font_select_o          = st.font_sel;
  assign fg_intensity_o         = st.intensity;
  assign font_base_o            = st.font_base;
  assign gfx_controller_index_o = st.gfx_controller_index;

  chk_blank_follows: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R01
    video_blank_o |-> !fetch_enable_o)
    else $error("blank without fetch stop");
  chk_plane_disable_wins: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R02
    $past(legacy_plane_disable_i) |-> !video_blank_o)
    else $error("blank while plane disabled");
  chk_quad_load: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R04
    st.clocking_mode[4] |-> load_interval_o == 3'h4)
    else $error("quad load interval wrong");
  chk_half_load: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R06
    (st.clocking_mode[4:2] == 3'b001) |-> load_interval_o == 3'h2)
    else $error("half load interval wrong");
  chk_dot_width: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R07
    char_dots_o == (st.clocking_mode[0] ? 4'h8 : 4'h9))
    else $error("character width wrong");
  chk_mask_gate: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R08
    (plane_write_en_o & ~st.plane_write_mask[3:0]) == 4'h0)
    else $error("write to masked plane");
  chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R20
    st.clocking_mode[7:6] == 2'h0 && st.memory_addressing_mode[0] == 1'b0)
    else $error("reserved bit stored");
  sequence s_seq_data_wr;
    io_wr_i && io_addr_i == 16'h03c5 && st.sequencer_index_port == 3'h2;
  endsequence
  chk_immediate_write: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R21
    s_seq_data_wr |=> st.plane_write_mask == {4'h0, $past(io_wdata_i[3:0])})
    else $error("write not taken at once");

  // Reset leaves the bank idle with fetches running
  sequence s_reset_done;
    $fell(srst_i);
  endsequence
  chk_reset_values: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R04 R07
    s_reset_done |-> !video_blank_o && fetch_enable_o && char_dots_o == lvs_pkg::DOTS_WIDE
    && load_interval_o == lvs_pkg::LOAD_EVERY_1 && !io_rvalid_o && cpu_addr_ok_o)
    else $error("reset values wrong");
  chk_fetch_runs: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R01
    !video_blank_o |-> fetch_enable_o)
    else $error("fetch stopped without blank");
  // Disable input is one edge older than the stored control
  chk_screen_off: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R01 R02
    video_blank_o == (st.clocking_mode[5] && !$past(legacy_plane_disable_i)))
    else $error("screen off blank wrong");
  chk_pixel_div: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R05
    pixel_div2_o == st.clocking_mode[3])
    else $error("dot clock divide wrong");
  chk_single_load: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R06
    (st.clocking_mode[4] == 1'b0 && st.clocking_mode[2] == 1'b0) |-> load_interval_o == 3'h1)
    else $error("single load interval wrong");

  // Plane routing is judged one edge after the request
  sequence s_chain_write;
    cpu_wr_i && cpu_addr_i[17:16] == 2'h0 && next_st.memory_addressing_mode[3];
  endsequence
  chk_chain_plane: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R13
    s_chain_write |=> plane_write_en_o == ((4'h1 << $past(cpu_addr_i[1:0]))
                                           & st.plane_write_mask[3:0]))
    else $error("chain four plane wrong");
  sequence s_odd_even_write;
    cpu_wr_i && cpu_addr_i[17:16] == 2'h0 && next_st.memory_addressing_mode[3:2] == 2'h0;
  endsequence
  chk_odd_even_plane: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R14
    s_odd_even_write |=> plane_write_en_o == (($past(cpu_addr_i[0]) ? 4'ha : 4'h5)
                                              & st.plane_write_mask[3:0]))
    else $error("odd even plane wrong");
  chk_window_block: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R15
    cpu_addr_i[17:16] != 2'h0 && !next_st.memory_addressing_mode[1]
    |=> !cpu_addr_ok_o && plane_write_en_o == 4'h0)
    else $error("access outside 64 KB window");
  chk_window_open: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R15
    next_st.memory_addressing_mode[1] |=> cpu_addr_ok_o)
    else $error("extended window refused");
  chk_no_write_idle: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R08
    !cpu_wr_i |=> plane_write_en_o == 4'h0)
    else $error("plane enabled without a write");

  // Attribute bit 3 has one meaning at a time
  chk_font_or_bright: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R09
    !(font_select_o && fg_intensity_o))
    else $error("attribute bit used twice");
  chk_font_map_off: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R10
    !st.memory_addressing_mode[1] |-> !font_select_o && font_base_o[15:14] == 2'h0)
    else $error("font select without extended memory");
  chk_font_align: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R11 R12
    font_base_o[12:0] == 13'h0000)
    else $error("font table not 8 KB aligned");
  sequence s_same_maps;
    text_mode_i && attr_bit3_i && next_st.font_map_select[5] == next_st.font_map_select[4]
    && next_st.font_map_select[3:2] == next_st.font_map_select[1:0];
  endsequence
  chk_same_maps: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R09
    s_same_maps |=> fg_intensity_o && !font_select_o)
    else $error("equal maps not intensity");

  // Old parts froze the counter here; this one must not
  sequence s_hold_write;
    io_wr_i && io_addr_i == lvs_pkg::IO_SEQ_DATA
    && st.sequencer_index_port == lvs_pkg::IDX_CHAR_HOLD;
  endsequence
  chk_hold_inert: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R16
    s_hold_write |=> $stable(load_interval_o) && $stable(char_dots_o)
    && $stable(pixel_div2_o))
    else $error("hold write disturbed timing");

  chk_gfx_index: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R17
    io_wr_i && io_addr_i == lvs_pkg::IO_GFX_INDEX
    |=> gfx_controller_index_o == $past(io_wdata_i[4:0]))
    else $error("graphics index not stored");
  chk_gfx_data_off: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R17
    io_rd_i && io_addr_i == lvs_pkg::IO_GFX_DATA |=> !io_rvalid_o)
    else $error("graphics data port answered");

  // Host reads answer exactly one edge after the strobe
  sequence s_seq_read;
    io_rd_i && (io_addr_i == lvs_pkg::IO_SEQ_INDEX || io_addr_i == lvs_pkg::IO_SEQ_DATA);
  endsequence
  chk_read_answer: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R19
    s_seq_read |=> io_rvalid_o)
    else $error("read not answered");
  chk_rvalid_pulse: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R19
    io_rvalid_o |-> $past(io_rd_i))
    else $error("read answer without strobe");
  chk_index_store: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R19
    io_wr_i && io_addr_i == lvs_pkg::IO_SEQ_INDEX
    |=> st.sequencer_index_port == $past(io_wdata_i[2:0]))
    else $error("sequencer index not stored");
  sequence s_index_read;
    io_rd_i && io_addr_i == lvs_pkg::IO_SEQ_INDEX;
  endsequence
  chk_index_read: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R19 R20
    s_index_read |=> io_rdata_o == {5'h00, $past(st.sequencer_index_port)})
    else $error("index read back wrong");
  sequence s_mask_read;
    io_rd_i && io_addr_i == lvs_pkg::IO_SEQ_DATA
    && st.sequencer_index_port == lvs_pkg::IDX_PLANE_MASK;
  endsequence
  chk_mask_read: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R19 R20
    s_mask_read |=> io_rdata_o == {4'h0, $past(st.plane_write_mask[3:0])})
    else $error("plane mask read back wrong");
  chk_reserved_mask: assert property (@(posedge core_clk_i) disable iff (srst_i) // see R20
    st.plane_write_mask[7:4] == 4'h0 && st.font_map_select[7:6] == 2'h0)
    else $error("reserved mask or font bit stored");
endmodule

// ---- bench/lvs_host_model.sv ----
// Host model issuing legacy index/data I/O port cycles
`timescale 1ns/1ps
module lvs_host_model #(
  parameter int WAIT_CYC = 20000
) (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        rvalid_i,
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  wdata_o,
  output logic             plane_off_o
);
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
    plane_off_o = 1'b0;
  end
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd);
    @(posedge clk_i);
    #1;
    addr_o = a; // I/O space only
    wdata_o = d;
    wr_o = !rd;
    rd_o = rd;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a; // Idle bus shows no stale address
    wdata_o = ~d;
  endtask
  task automatic seq_wr(input logic [2:0] idx, input logic [7:0] d);
    cyc(16'h03c4, {5'h00, idx}, 1'b0);
    cyc(16'h03c5, d, 1'b0);
  endtask
  task automatic seq_rd(input logic [2:0] idx, output logic [7:0] d, output logic v);
    cyc(16'h03c4, {5'h00, idx}, 1'b0);
    cyc(16'h03c5, 8'h00, 1'b1);
    // Answer stands only in this cycle
    d = rdata_i;
    v = rvalid_i;
  endtask
  // Screen off, long wait, then drop the legacy plane
  task automatic plane_off;
    seq_wr(3'h1, 8'h20);
    repeat (WAIT_CYC) @(posedge clk_i);
    #1;
    plane_off_o = 1'b1;
  endtask
endmodule

// ---- bench/lvs_seq_regs_tb.sv ----
// Self-checking bench for the sequencer register bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module lvs_seq_regs_tb;
  logic core_clk_i, srst_i, io_wr_i, io_rd_i, legacy_plane_disable_i;
  logic text_mode_i, attr_bit3_i, cpu_wr_i, io_rvalid_o, video_blank_o;
  logic fetch_enable_o, pixel_div2_o, cpu_addr_ok_o, font_select_o, fg_intensity_o;
  logic [15:0] io_addr_i, font_base_o;
  logic [7:0]  io_wdata_i, io_rdata_o, d;
  logic [17:0] cpu_addr_i;
  logic [2:0]  load_interval_o;
  logic [3:0]  char_dots_o, plane_write_en_o;
  logic [4:0]  gfx_controller_index_o;
  logic        v;
  int          bad_count = 0;
  int          checks = 0;
  lvs_seq_regs u_dut (.core_clk_i, .srst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
    .legacy_plane_disable_i, .text_mode_i, .attr_bit3_i, .cpu_wr_i, .cpu_addr_i,
    .io_rdata_o, .io_rvalid_o, .video_blank_o, .fetch_enable_o, .load_interval_o,
    .pixel_div2_o, .char_dots_o, .plane_write_en_o, .cpu_addr_ok_o, .font_select_o,
    .fg_intensity_o, .font_base_o, .gfx_controller_index_o);
  lvs_host_model u_host (.clk_i(core_clk_i), .rdata_i(io_rdata_o), .rvalid_i(io_rvalid_o),
    .addr_o(io_addr_i), .wr_o(io_wr_i), .rd_o(io_rd_i), .wdata_o(io_wdata_i),
    .plane_off_o(legacy_plane_disable_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic rd(input logic [2:0] idx, input logic [7:0] e);
    u_host.seq_rd(idx, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask
  task automatic cpu(input logic [7:0] mode, input logic [17:0] a, input logic [3:0] e);
    u_host.seq_wr(3'h4, mode);
    cpu_addr_i = a;
    settle(2);
    `CHK(plane_write_en_o, e)
  endtask
  task automatic t_reset;
    `CHK(video_blank_o, 1'b0)
    `CHK(fetch_enable_o, 1'b1)
    `CHK(load_interval_o, lvs_pkg::LOAD_EVERY_1)
    `CHK(char_dots_o, lvs_pkg::DOTS_WIDE)
    `CHK(gfx_controller_index_o, 5'h00)
    for (int i = 1; i < 5; i++) rd(i[2:0], 8'h00);
    rd(3'h7, 8'h00);
  endtask
  task automatic t_clock;
    u_host.seq_wr(3'h1, 8'hff);
    settle(1);
    `CHK(video_blank_o, 1'b1)
    `CHK(fetch_enable_o, 1'b0)
    `CHK(load_interval_o, lvs_pkg::LOAD_EVERY_4)
    `CHK(pixel_div2_o, 1'b1)
    `CHK(char_dots_o, lvs_pkg::DOTS_NARROW)
    rd(3'h1, 8'h3d);
    u_host.seq_wr(3'h1, 8'h04);
    settle(1);
    `CHK(load_interval_o, lvs_pkg::LOAD_EVERY_2)
    `CHK(pixel_div2_o, 1'b0)
    `CHK(char_dots_o, lvs_pkg::DOTS_WIDE)
    `CHK(video_blank_o, 1'b0)
  endtask
  task automatic t_route;
    u_host.seq_wr(3'h2, 8'hf6);
    rd(3'h2, 8'h06);
    cpu_wr_i = 1'b1;
    for (int a = 0; a < 4; a++) cpu(8'h08, 18'(a), (4'h1 << a) & 4'h6);
    cpu(8'h00, 18'h00000, 4'h4);
    cpu(8'h00, 18'h00001, 4'h2);
    cpu(8'h04, 18'h00001, 4'h6);
    cpu(8'h00, 18'h10000, 4'h0);
    `CHK(cpu_addr_ok_o, 1'b0)
    cpu(8'h02, 18'h30000, 4'h4);
    `CHK(cpu_addr_ok_o, 1'b1)
    cpu_wr_i = 1'b0;
    settle(2);
    `CHK(plane_write_en_o, 4'h0)
    u_host.seq_wr(3'h4, 8'hff);
    rd(3'h4, 8'h0e);
  endtask
  task automatic t_font;
    u_host.seq_wr(3'h4, 8'h02);
    u_host.seq_wr(3'h3, 8'he4);
    rd(3'h3, 8'h24);
    text_mode_i = 1'b1;
    attr_bit3_i = 1'b1;
    settle(2);
    `CHK(font_select_o, 1'b1)
    `CHK(fg_intensity_o, 1'b0)
    `CHK(font_base_o, 16'h6000)
    u_host.seq_wr(3'h3, 8'h11);
    attr_bit3_i = 1'b0;
    settle(2);
    `CHK(font_base_o, 16'h6000)
    u_host.seq_wr(3'h3, 8'h00);
    attr_bit3_i = 1'b1;
    settle(2);
    `CHK(fg_intensity_o, 1'b1)
    `CHK(font_select_o, 1'b0)
    u_host.seq_wr(3'h4, 8'h00);
    u_host.seq_wr(3'h3, 8'h0c);
    settle(2);
    `CHK(font_base_o == 16'h0000 || font_base_o == 16'h2000, 1'b1)
    `CHK(font_select_o, 1'b0)
    `CHK(fg_intensity_o, 1'b1)
  endtask
  task automatic t_misc;
    u_host.seq_wr(3'h7, 8'h5a);
    rd(3'h7, 8'h5a);
    `CHK(load_interval_o, lvs_pkg::LOAD_EVERY_2)
    u_host.seq_wr(3'h0, 8'hff);
    rd(3'h0, 8'h00);
    u_host.cyc(16'h03ce, 8'hff, 1'b0);
    settle(1);
    `CHK(gfx_controller_index_o, 5'h1f)
    u_host.cyc(16'h03ce, 8'h00, 1'b1);
    `CHK(io_rvalid_o, 1'b1)
    `CHK(io_rdata_o, 8'h1f)
    u_host.cyc(16'h03cf, 8'h00, 1'b1);
    `CHK(io_rvalid_o, 1'b0)
    u_host.plane_off();
    settle(2);
    `CHK(video_blank_o, 1'b0)
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk_i);
    bad_count++;
    report_and_stop();
  end
  initial begin
    srst_i = 1'b1;
    text_mode_i = 1'b0;
    attr_bit3_i = 1'b0;
    cpu_wr_i = 1'b0;
    cpu_addr_i = 18'h00000;
    settle(3);
    srst_i = 1'b0;
    t_reset();
    t_clock();
    t_route();
    t_font();
    t_misc();
    report_and_stop();
  end
endmodule
